// ---- verilog/ampmpc_pkg.sv ----
package ampmpc_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INIT_TIME_NS = 100000;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CNT_W = $clog2(INIT_CYCLES + 1);
    // device register offsets
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
    localparam logic [7:0] ADDR_MODE = 8'h02;
    localparam logic [7:0] ADDR_SLEEP = 8'h03;
    localparam logic [7:0] ADDR_POWER = 8'h07;
    localparam logic [7:0] ADDR_PDM_CONFIG = 8'h1c;
    localparam logic [7:0] ADDR_PDM_IN_DIV = 8'h1d;
    localparam logic [7:0] ADDR_PDM_OUT_DIV = 8'h1e;
    // device reset values
    localparam logic [3:0] RST_MODE = 4'h1;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_PDM_CONFIG = 8'h00;
    localparam logic [7:0] RST_DIV = 8'h08;
    localparam logic [7:0] RST_SLEEP = 8'h00;
    // device field positions
    localparam int SRESET_BIT = 0;
    localparam int SLEEP_BIT = 7;
    localparam int DIV_POWER_BIT = 7;
    localparam int OUT_DIR_BIT = 0;
    localparam int IN_DIR_BIT = 1;
    localparam int PS_MSB = 7;
    localparam int PS_LSB = 6;
    // processing modes
    localparam logic [3:0] MODE_PCM = 4'h1;
    localparam logic [3:0] MODE_PCM_PCMSNS = 4'h2;
    localparam logic [3:0] MODE_PCM_PDMSNS = 4'h3;
    localparam logic [3:0] MODE_PDM = 4'h4;
    localparam logic [3:0] MODE_PDM_PDMSNS = 4'h5;
    // power states
    localparam logic [1:0] PS_DOWN = 2'h0;
    localparam logic [1:0] PS_BOOST = 2'h1;
    localparam logic [1:0] PS_NOBOOST = 2'h2;
    // controller apb map
    localparam logic [7:0] APB_CTRL = 8'h00;
    localparam logic [7:0] APB_XFER = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam int CTRL_RELEASE = 0;
    localparam int CTRL_BCLK_SLOW = 1;
    localparam int CTRL_PDM_SLOW = 2;
    localparam int CTRL_ASI_OUT = 3;
    localparam int XFER_WRITE_BIT = 16;
    localparam int ST_BUSY = 8;
    localparam int ST_REFUSED = 9;
    localparam int ST_MCLK = 10;
    localparam int ST_READY = 11;

    // master clock needed for the chosen mode and clocking
    function automatic logic ampmpc_mclk_needed(input logic [3:0] mode, input logic in_master,
            input logic out_master, input logic asi_out, input logic bclk_slow, input logic pdm_slow);
        logic need;
        need = 1'b1;
        if (mode == MODE_PCM || mode == MODE_PCM_PCMSNS) begin
            need = bclk_slow | asi_out;
        end else if (mode == MODE_PCM_PDMSNS) begin
            need = (!asi_out & bclk_slow) | (!out_master & pdm_slow) | (asi_out & out_master);
        end else if (mode == MODE_PDM) begin
            need = in_master | bclk_slow;
        end else if (mode == MODE_PDM_PDMSNS) begin
            need = !((!in_master & !bclk_slow) | (!out_master & !pdm_slow));
        end
        return need;
    endfunction
endpackage

// ---- verilog/ampmpc_link_if.sv ----
`timescale 1ns/1ps
interface ampmpc_link_if;
    logic hw_shutdown_n;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    modport dev (
        input hw_shutdown_n,
        input req,
        input we,
        input addr,
        input wdata,
        output ack,
        output rdata
    );
    modport ctl (
        output hw_shutdown_n,
        output req,
        output we,
        output addr,
        output wdata,
        input ack,
        input rdata
    );
endinterface

// ---- verilog/ampmpc_device.sv ----
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ampmpc_device
    import ampmpc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    ampmpc_link_if.dev link,
    input wire logic i_system_fault,
    input wire logic i_fault_auto_retry,
    input wire logic i_rate_96k,
    input wire logic i_asi_clk_out,
    input wire logic i_bclk_slow,
    input wire logic i_pdm_slow,
    output logic o_hw_shutdown,
    output logic o_init_busy,
    output logic o_analog_power,
    output logic o_boost_en,
    output logic o_sense_power,
    output logic o_sense_pcm_return,
    output logic o_sense_pdm_out,
    output logic o_dout_used,
    output logic o_bclk_is_pdm_clk,
    output logic o_din_is_pdm,
    output logic o_density_clock_pin_used,
    output logic o_pdm_out_clk_drive,
    output logic o_pdm_in_clk_drive,
    output logic o_in_div_power,
    output logic o_out_div_power,
    output logic o_por_monitor_en,
    output logic o_guard_avail,
    output logic o_mode_valid,
    output logic o_mclk_root
);
    // the pin acts as an asynchronous clear of the whole core
    wire core_rst_n = i_reset_n & link.hw_shutdown_n;

    logic [3:0] mode_reg;
    logic [7:0] power_reg;
    logic [7:0] cfg_reg;
    logic [7:0] in_div_reg;
    logic [7:0] out_div_reg;
    logic [7:0] sleep_reg;
    logic [INIT_CNT_W-1:0] init_cnt_reg;
    logic [INIT_CNT_W-1:0] init_cnt_next;
    logic ack_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // bus decode
    wire busy = init_cnt_reg != '0;
    wire take = link.req & !ack_reg & !busy;
    wire wr = take & link.we;
    wire wr_sreset = wr && link.addr == ADDR_SOFT_RESET && link.wdata[SRESET_BIT];
    wire wr_mode = wr && link.addr == ADDR_MODE;
    wire wr_sleep = wr && link.addr == ADDR_SLEEP;
    wire wr_power = wr && link.addr == ADDR_POWER;
    wire wr_cfg = wr && link.addr == ADDR_PDM_CONFIG;
    wire wr_in_div = wr && link.addr == ADDR_PDM_IN_DIV;
    wire wr_out_div = wr && link.addr == ADDR_PDM_OUT_DIV;
    wire fault_down = i_system_fault & !i_fault_auto_retry;

    always_comb begin
        rdata_next = 8'h00;
        unique case (link.addr)
            ADDR_MODE: rdata_next = {4'h0, mode_reg};
            ADDR_SLEEP: rdata_next = sleep_reg;
            ADDR_POWER: rdata_next = power_reg;
            ADDR_PDM_CONFIG: rdata_next = cfg_reg;
            ADDR_PDM_IN_DIV: rdata_next = in_div_reg;
            ADDR_PDM_OUT_DIV: rdata_next = out_div_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    assign init_cnt_next = wr_sreset ? INIT_CNT_W'(INIT_CYCLES) :
                           busy ? init_cnt_reg - INIT_CNT_W'(1) : init_cnt_reg;

    // link answer
    always_ff @(posedge i_mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            init_cnt_reg <= '0;
        end else if (i_ce) begin
            ack_reg <= take;
            rdata_reg <= take ? rdata_next : rdata_reg;
            init_cnt_reg <= init_cnt_next;
        end
    end

    // mode, sleep and clocking registers
    always_ff @(posedge i_mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            mode_reg <= RST_MODE;
            sleep_reg <= RST_SLEEP;
            cfg_reg <= RST_PDM_CONFIG;
            in_div_reg <= RST_DIV;
            out_div_reg <= RST_DIV;
        end else if (i_ce) begin
            if (wr_sreset) begin
                mode_reg <= RST_MODE;
                sleep_reg <= RST_SLEEP;
                cfg_reg <= RST_PDM_CONFIG;
                in_div_reg <= RST_DIV;
                out_div_reg <= RST_DIV;
            end else begin
                if (wr_mode) begin
                    mode_reg <= link.wdata[3:0];
                end
                if (wr_sleep) begin
                    sleep_reg <= link.wdata;
                end
                if (wr_cfg) begin
                    cfg_reg <= link.wdata;
                end
                if (wr_in_div) begin
                    in_div_reg <= link.wdata;
                end
                if (wr_out_div) begin
                    out_div_reg <= link.wdata;
                end
            end
        end
    end

    // power state; a fault with auto-retry off wins over a host power write, but a soft reset wins over the fault, in the same cycle
    always_ff @(posedge i_mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            power_reg <= RST_POWER;
        end else if (i_ce) begin
            if (wr_sreset) begin
                power_reg <= RST_POWER;
            end else if (fault_down) begin
                power_reg <= {PS_DOWN, power_reg[PS_LSB-1:0]};
            end else if (wr_power) begin
                power_reg <= link.wdata;
            end
        end
    end

    // output decode
    wire [1:0] ps = power_reg[PS_MSB:PS_LSB];
    wire powered = (ps == PS_BOOST || ps == PS_NOBOOST) & !busy;
    wire is_pcm = mode_reg == MODE_PCM;
    wire is_pcm_sns = mode_reg == MODE_PCM_PCMSNS;
    wire is_pcm_pdm = mode_reg == MODE_PCM_PDMSNS;
    wire is_pdm = mode_reg == MODE_PDM;
    wire is_pdm_pdm = mode_reg == MODE_PDM_PDMSNS;
    wire valid = is_pcm | is_pcm_sns | is_pcm_pdm | is_pdm | is_pdm_pdm;
    wire sense_mode = is_pcm_sns | is_pcm_pdm | is_pdm_pdm;
    wire pdm_in = is_pdm | is_pdm_pdm;
    wire density_clock_used = is_pcm_pdm | is_pdm_pdm;
    wire guard = valid & !(is_pcm_sns & i_rate_96k);
    wire mclk_need = ampmpc_mclk_needed(mode_reg, cfg_reg[IN_DIR_BIT], cfg_reg[OUT_DIR_BIT],
                                        i_asi_clk_out, i_bclk_slow, i_pdm_slow);

    always_ff @(posedge i_mclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            o_hw_shutdown <= 1'b1;
            o_init_busy <= 1'b0;
            o_analog_power <= 1'b0;
            o_boost_en <= 1'b0;
            o_sense_power <= 1'b0;
            o_sense_pcm_return <= 1'b0;
            o_sense_pdm_out <= 1'b0;
            o_dout_used <= 1'b0;
            o_bclk_is_pdm_clk <= 1'b0;
            o_din_is_pdm <= 1'b0;
            o_density_clock_pin_used <= 1'b0;
            o_pdm_out_clk_drive <= 1'b0;
            o_pdm_in_clk_drive <= 1'b0;
            o_in_div_power <= 1'b0;
            o_out_div_power <= 1'b0;
            o_por_monitor_en <= 1'b1;
            o_guard_avail <= 1'b0;
            o_mode_valid <= 1'b0;
            o_mclk_root <= 1'b0;
        end else if (i_ce) begin
            o_hw_shutdown <= 1'b0;
            o_init_busy <= busy;
            o_analog_power <= powered;
            o_boost_en <= powered & (ps == PS_BOOST);
            o_sense_power <= powered & sense_mode;
            o_sense_pcm_return <= is_pcm_sns;
            o_sense_pdm_out <= is_pcm_pdm | is_pdm_pdm;
            o_dout_used <= sense_mode;
            o_bclk_is_pdm_clk <= pdm_in;
            o_din_is_pdm <= pdm_in;
            o_density_clock_pin_used <= density_clock_used;
            o_pdm_out_clk_drive <= density_clock_used & cfg_reg[OUT_DIR_BIT];
            o_pdm_in_clk_drive <= pdm_in & cfg_reg[IN_DIR_BIT];
            o_in_div_power <= in_div_reg[DIV_POWER_BIT];
            o_out_div_power <= out_div_reg[DIV_POWER_BIT];
            o_por_monitor_en <= !sleep_reg[SLEEP_BIT];
            o_guard_avail <= guard;
            o_mode_valid <= valid;
            o_mclk_root <= mclk_need;
        end
    end

    assign link.ack = ack_reg;
    assign link.rdata = rdata_reg;
endmodule

// ---- verilog/ampmpc_host.sv ----
`timescale 1ns/1ps
module ampmpc_host
    import ampmpc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_mclk_required,
    ampmpc_link_if.ctl link
);
    typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} ampmpc_host_state_type;
    ampmpc_host_state_type state_reg;

    logic [3:0] ctrl_reg;
    logic req_reg;
    logic we_reg;
    logic [7:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic refused_reg;
    logic ready_reg;
    logic sreset_pend_reg;
    logic [INIT_CNT_W-1:0] wait_reg;
    logic [3:0] sh_mode_reg;
    logic [1:0] sh_ps_reg;
    logic [7:0] sh_cfg_reg;
    logic sh_in_div_reg;
    logic sh_out_div_reg;

    // apb decode; writes land in the access cycle
    wire setup = i_psel & !i_penable;
    wire access = i_psel & i_penable & o_pready;
    wire mapped = i_paddr == APB_CTRL || i_paddr == APB_XFER || i_paddr == APB_STATUS;
    wire wr_ctrl = access & i_pwrite & (i_paddr == APB_CTRL);
    wire wr_xfer = access & i_pwrite & (i_paddr == APB_XFER);
    wire [7:0] x_addr = i_pwdata[7:0];
    wire [7:0] x_data = i_pwdata[15:8];
    wire x_we = i_pwdata[XFER_WRITE_BIT];
    wire busy = state_reg != H_IDLE;
    wire bad_mode = x_we && x_addr == ADDR_MODE && sh_ps_reg != PS_DOWN;
    wire bad_cfg = x_we && x_addr == ADDR_PDM_CONFIG &&
                   ((!x_data[IN_DIR_BIT] && !sh_in_div_reg) ||
                    (!x_data[OUT_DIR_BIT] && !sh_out_div_reg));
    wire x_ok = !busy & ready_reg & !bad_mode & !bad_cfg;
    wire bad_down = wr_ctrl & !i_pwdata[CTRL_RELEASE] & ctrl_reg[CTRL_RELEASE] &
                    (sh_ps_reg != PS_DOWN);
    wire done = state_reg == H_REQ & link.ack;
    wire is_sreset = we_reg && addr_reg == ADDR_SOFT_RESET && wdata_reg[SRESET_BIT];
    wire [31:0] status = {20'h0, ready_reg, o_mclk_required, refused_reg, busy, rdata_reg};
    wire [31:0] rd_mux = i_paddr == APB_CTRL ? {28'h0, ctrl_reg} :
                         i_paddr == APB_STATUS ? status : 32'h0;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_mclk_required <= 1'b1;
            ctrl_reg <= 4'h0;
            refused_reg <= 1'b0;
        end else if (i_ce) begin
            o_prdata <= setup ? rd_mux : 32'h0;
            o_pready <= setup;
            o_pslverr <= setup & !mapped;
            o_mclk_required <= ampmpc_mclk_needed(sh_mode_reg, sh_cfg_reg[IN_DIR_BIT],
                sh_cfg_reg[OUT_DIR_BIT], ctrl_reg[CTRL_ASI_OUT], ctrl_reg[CTRL_BCLK_SLOW],
                ctrl_reg[CTRL_PDM_SLOW]);
            if (wr_ctrl & !bad_down) begin
                ctrl_reg <= i_pwdata[3:0];
            end
            if (wr_xfer | bad_down) begin
                refused_reg <= bad_down | !x_ok;
            end
        end
    end

    // link sequencer
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= H_IDLE;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            addr_reg <= 8'h00;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            ready_reg <= 1'b0;
            sreset_pend_reg <= 1'b0;
            wait_reg <= '0;
        end else if (i_ce) begin
            if (!ctrl_reg[CTRL_RELEASE]) begin
                state_reg <= H_IDLE;
                req_reg <= 1'b0;
                ready_reg <= 1'b0;
                sreset_pend_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    H_IDLE: begin
                        if (sreset_pend_reg) begin
                            sreset_pend_reg <= 1'b0;
                            state_reg <= H_REQ;
                            req_reg <= 1'b1;
                            we_reg <= 1'b1;
                            addr_reg <= ADDR_SOFT_RESET;
                            wdata_reg <= 8'h01;
                        end else if (wr_xfer & x_ok) begin
                            state_reg <= H_REQ;
                            req_reg <= 1'b1;
                            we_reg <= x_we;
                            addr_reg <= x_addr;
                            wdata_reg <= x_data;
                        end
                    end
                    H_REQ: begin
                        if (link.ack) begin
                            req_reg <= 1'b0;
                            rdata_reg <= we_reg ? rdata_reg : link.rdata;
                            state_reg <= is_sreset ? H_WAIT : H_IDLE;
                            wait_reg <= INIT_CNT_W'(INIT_CYCLES);
                            ready_reg <= ready_reg & !is_sreset;
                        end
                    end
                    H_WAIT: begin
                        wait_reg <= wait_reg - INIT_CNT_W'(1);
                        if (wait_reg == INIT_CNT_W'(1)) begin
                            state_reg <= H_IDLE;
                            ready_reg <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // shadow of the device state used for host-side checks
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sh_mode_reg <= RST_MODE;
            sh_ps_reg <= PS_DOWN;
            sh_cfg_reg <= RST_PDM_CONFIG;
            sh_in_div_reg <= 1'b0;
            sh_out_div_reg <= 1'b0;
        end else if (i_ce) begin
            if (!ctrl_reg[CTRL_RELEASE] || (done && is_sreset)) begin
                sh_mode_reg <= RST_MODE;
                sh_ps_reg <= PS_DOWN;
                sh_cfg_reg <= RST_PDM_CONFIG;
                sh_in_div_reg <= RST_DIV[DIV_POWER_BIT];
                sh_out_div_reg <= RST_DIV[DIV_POWER_BIT];
            end else if (done) begin
                if (addr_reg == ADDR_MODE && we_reg) begin
                    sh_mode_reg <= wdata_reg[3:0];
                end
                if (addr_reg == ADDR_POWER) begin
                    sh_ps_reg <= we_reg ? wdata_reg[PS_MSB:PS_LSB] : link.rdata[PS_MSB:PS_LSB];
                end
                if (addr_reg == ADDR_PDM_CONFIG && we_reg) begin
                    sh_cfg_reg <= wdata_reg;
                end
                if (addr_reg == ADDR_PDM_IN_DIV && we_reg) begin
                    sh_in_div_reg <= wdata_reg[DIV_POWER_BIT];
                end
                if (addr_reg == ADDR_PDM_OUT_DIV && we_reg) begin
                    sh_out_div_reg <= wdata_reg[DIV_POWER_BIT];
                end
            end
        end
    end

    assign link.hw_shutdown_n = ctrl_reg[CTRL_RELEASE];
    assign link.req = req_reg;
    assign link.we = we_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wdata_reg;
endmodule

// ---- test/ampmpc_link_properties.sv ----
`timescale 1ns/1ps
module ampmpc_link_properties
    import ampmpc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic hw_shutdown_n,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);
    logic [1:0] power_seen;
    logic [10:0] gap;
    wire sreset_ack = ack && we && addr == ADDR_SOFT_RESET && wdata[SRESET_BIT];
    // power field as the host last saw it, and a guard span after a soft reset
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            power_seen <= 2'h0;
            gap <= 11'h0;
        end else begin
            if (!hw_shutdown_n || sreset_ack) begin
                power_seen <= 2'h0;
            end else if (ack && addr == ADDR_POWER) begin
                power_seen <= we ? wdata[7:6] : rdata[7:6];
            end
            gap <= sreset_ack ? 11'(INIT_CYCLES - 10) : (gap != 0 ? gap - 11'h1 : gap);
        end
    end
    sequence s_soft_reset_req;
        req && we && addr == ADDR_SOFT_RESET && wdata[SRESET_BIT];
    endsequence
    property p_ack_cause;
        ack |-> $past(req) && !$past(ack);
    endproperty
    property p_req_hold;
        req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
    endproperty
    property p_req_drop;
        ack |=> !req;
    endproperty
    property p_shut_quiet;
        !hw_shutdown_n |-> !ack && rdata == 8'h00;
    endproperty
    property p_rdata_hold;
        disable iff (!i_reset_n || !hw_shutdown_n) !ack |-> $stable(rdata);
    endproperty
    property p_init_gap;
        $rose(req) |-> gap == 11'h0;
    endproperty
    property p_mode_down;
        ack && we && addr == ADDR_MODE |-> power_seen == PS_DOWN || power_seen == 2'h3;
    endproperty
    property p_boot_reset;
        $rose(hw_shutdown_n) |-> ##[0:20] s_soft_reset_req;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    a_shut_quiet: assert property (p_shut_quiet) else $error("answer in shutdown");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_init_gap: assert property (p_init_gap) else $error("request during init");
    a_mode_down: assert property (p_mode_down) else $error("mode written while powered");
    a_boot_reset: assert property (p_boot_reset) else $error("no soft reset after release");
endmodule

// ---- test/amp_mode_power_control_tb.sv ----
`timescale 1ns/1ps
module amp_mode_power_control_tb;
    import ampmpc_pkg::*;
    logic i_mclk = 0, i_reset_n = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, q, st;
    logic i_system_fault = 0, i_fault_auto_retry = 0, i_rate_96k = 0, i_asi_clk_out = 0, i_bclk_slow = 0;
    logic i_pdm_slow = 0, o_pready, o_pslverr, o_mclk_required, err;
    logic o_hw_shutdown, o_init_busy, o_analog_power, o_boost_en, o_sense_power, o_sense_pcm_return;
    logic o_sense_pdm_out, o_dout_used, o_bclk_is_pdm_clk, o_din_is_pdm, o_density_clock_pin_used;
    logic o_pdm_out_clk_drive, o_pdm_in_clk_drive, o_in_div_power, o_out_div_power, o_por_monitor_en;
    logic o_guard_avail, o_mode_valid, o_mclk_root;
    int n_errors = 0, checked = 0;
    ampmpc_link_if link();
    ampmpc_host ampmpc_host_inst (.*);
    ampmpc_device ampmpc_device_inst (.*);
    ampmpc_link_properties ampmpc_link_properties_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
        .hw_shutdown_n(link.hw_shutdown_n), .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
    task automatic end_of_test();
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_mclk);
        end while (o_pready !== 1'b1);
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wait_idle();
        do begin
            apb(1'b0, APB_STATUS, 32'h0);
        end while (q[ST_BUSY] !== 1'b0 || q[ST_READY] !== 1'b1);
        st = q;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, APB_XFER, {15'h0, wr, d, a});
        wait_idle();
    endtask
    task automatic t_release();
        apb(1'b1, APB_CTRL, 32'h1);
        wait_idle();
        chk("ready", st[ST_READY], 32'h1);
        chk("hw_shutdown", o_hw_shutdown, 32'h0);
        chk("analog", o_analog_power, 32'h0);
        xfer(1'b0, ADDR_SLEEP, 8'h00);
        chk("sleep", st[7:0], 32'h0);
    endtask
    task automatic t_modes();
        logic [3:0] m;
        i_bclk_slow <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            m = 4'(i);
            xfer(1'b1, ADDR_MODE, {4'h0, m});
            chk("mode_valid", o_mode_valid, 32'(m != 0));
            chk("dout_used", o_dout_used, 32'(m == 2 || m == 3 || m == 5));
            chk("pcm_return", o_sense_pcm_return, 32'(m == 2));
            chk("din_pdm", o_din_is_pdm, 32'(m >= 4));
            chk("bclk_pdm", o_bclk_is_pdm_clk, 32'(m >= 4));
            chk("clock_pin_used", o_density_clock_pin_used, 32'(m == 3 || m == 5));
            chk("sense_pdm", o_sense_pdm_out, 32'(m == 3 || m == 5));
            chk("mclk_root", o_mclk_root, 32'(m != 5));
            chk("mclk_required", o_mclk_required, 32'(m == 0));
        end
        xfer(1'b1, ADDR_MODE, 8'h02);
        i_rate_96k <= 1'b1;
        repeat (3) @(posedge i_mclk);
        chk("guard", o_guard_avail, 32'h0);
        i_rate_96k <= 1'b0;
        i_bclk_slow <= 1'b0;
        xfer(1'b1, ADDR_MODE, 8'h02);
        chk("guard", o_guard_avail, 32'h1);
    endtask
    task automatic t_power();
        xfer(1'b1, ADDR_POWER, 8'h40);
        chk("boost", o_boost_en, 32'h1);
        chk("sense_power", o_sense_power, 32'h1);
        xfer(1'b1, ADDR_MODE, 8'h04);
        chk("refused", st[ST_REFUSED], 32'h1);
        xfer(1'b1, ADDR_POWER, 8'h80);
        chk("boost", o_boost_en, 32'h0);
        chk("analog", o_analog_power, 32'h1);
        i_fault_auto_retry <= 1'b1;
        i_system_fault <= 1'b1;
        repeat (4) @(posedge i_mclk);
        chk("analog", o_analog_power, 32'h1);
        i_fault_auto_retry <= 1'b0;
        for (int n = 0; n < 20 && o_analog_power !== 1'b0; n++)
            @(posedge i_mclk);
        chk("analog", o_analog_power, 32'h0);
        i_system_fault <= 1'b0;
        xfer(1'b0, ADDR_POWER, 8'h00);
        chk("power", st[7:0], 32'h0);
    endtask
    task automatic t_pdm();
        xfer(1'b1, ADDR_SLEEP, 8'h80);
        chk("por", o_por_monitor_en, 32'h0);
        xfer(1'b1, ADDR_PDM_CONFIG, 8'h00);
        chk("refused", st[ST_REFUSED], 32'h1);
        xfer(1'b1, ADDR_PDM_IN_DIV, 8'h88);
        xfer(1'b1, ADDR_PDM_OUT_DIV, 8'h88);
        chk("in_div", o_in_div_power, 32'h1);
        chk("out_div", o_out_div_power, 32'h1);
        xfer(1'b1, ADDR_MODE, 8'h05);
        xfer(1'b1, ADDR_PDM_CONFIG, 8'h03);
        chk("out_drive", o_pdm_out_clk_drive, 32'h1);
        xfer(1'b1, ADDR_PDM_CONFIG, 8'h02);
        chk("refused", st[ST_REFUSED], 32'h0);
        chk("out_drive", o_pdm_out_clk_drive, 32'h0);
        chk("in_drive", o_pdm_in_clk_drive, 32'h1);
        chk("mclk_root", o_mclk_root, 32'h0);
        chk("mclk_required", o_mclk_required, 32'h0);
        i_pdm_slow <= 1'b1;
        apb(1'b1, APB_CTRL, 32'h5);
        repeat (3) @(posedge i_mclk);
        chk("mclk_root", o_mclk_root, 32'h1);
        chk("mclk_required", o_mclk_required, 32'h1);
        i_pdm_slow <= 1'b0;
    endtask
    task automatic t_soft_reset();
        apb(1'b1, APB_XFER, {15'h0, 1'b1, 8'h01, ADDR_SOFT_RESET});
        repeat (4) @(posedge i_mclk);
        chk("init_busy", o_init_busy, 32'h1);
        wait_idle();
        chk("init_busy", o_init_busy, 32'h0);
        xfer(1'b0, ADDR_MODE, 8'h00);
        chk("mode", st[7:0], 32'h1);
        xfer(1'b0, ADDR_SOFT_RESET, 8'h00);
        chk("reset_bit", st[7:0], 32'h0);
        chk("por", o_por_monitor_en, 32'h1);
        xfer(1'b0, ADDR_PDM_IN_DIV, 8'h00);
        chk("in_div", st[7:0], 32'h08);
    endtask
    task automatic t_hw_cycle();
        xfer(1'b1, ADDR_SLEEP, 8'h80);
        xfer(1'b1, ADDR_POWER, 8'h40);
        chk("sense_power", o_sense_power, 32'h0);
        apb(1'b1, APB_CTRL, 32'h0);
        wait_idle();
        chk("refused", st[ST_REFUSED], 32'h1);
        chk("hw_shutdown", o_hw_shutdown, 32'h0);
        xfer(1'b1, ADDR_POWER, 8'h00);
        chk("analog", o_analog_power, 32'h0);
        xfer(1'b0, ADDR_SLEEP, 8'h00);
        chk("sleep", st[7:0], 32'h80);
        apb(1'b1, APB_CTRL, 32'h0);
        repeat (3) @(posedge i_mclk);
        chk("hw_shutdown", o_hw_shutdown, 32'h1);
    endtask
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (40000) @(posedge i_mclk);
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        chk("hw_shutdown", o_hw_shutdown, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", err, 32'h1);
        t_release();
        t_modes();
        t_power();
        t_pdm();
        t_soft_reset();
        t_hw_cycle();
        t_release();
        end_of_test();
    end
endmodule
